/* nv_store.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Nonvolatile store seen by the block
// ----------------------------------------
// The image survives every reset, so a power cycle of the block sees what it last wrote.
module nv_store #(
  parameter logic [24:0] INIT_IMG = 25'h100_0000
) (
  input  wire logic               clk_i,
  input  wire logic               we_i,
  input  wire relay_cmd_pkg::nv_s wr_img_i,
  output relay_cmd_pkg::nv_s      rd_img_o
);
  relay_cmd_pkg::nv_s img = INIT_IMG;

  // Capture the image on the write pulse; no reset touches it.
  always @(posedge clk_i) begin
    if (we_i) begin
      img <= wr_img_i;
    end
  end

  assign rd_img_o = img;
endmodule

/* relay_cmd.sv */
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "relay_cmd_regs.svh"

// Contract
// - Protocol read reports 10 for stored ASCII and 11 for stored Modbus.
// - Protocol set 0 means ASCII, 1 Modbus; stored, active after next power-on.
// - Start in Modbus by default; grounded strap at power-on forces ASCII.
// - Broadcast host-alive restarts the watchdog and gets no reply.
// - Status read returns 00 with flag clear and 04 with flag set.
// - Timeout flag is nonvolatile and only the reset-status command clears it.
// - Watchdog read returns enable digit and two-digit count of tenths.
// - Watchdog set stores enable and count 01 to FF, then acknowledges.
// - On expiry set the timeout flag and flash the LED while it stays set.
// - After timeout the watchdog read shows disabled but keeps the count.
// - Reset-status clears the flag, acknowledges and stops the LED flashing.
// - Stored-value read, selector P or S, replies value then 00.
// - Stored-value set copies present outputs into power-on or safe value.
// - Modbus read 0x01 serves live, safe and power-on coil regions.
// - Quantity 1 to 7; reply byte count 1, one bit per channel (the reply here holds no byte count, only function code and data byte).
// - A failed Modbus read returns 0x81 and one exception code.
// - Valid status read gets !, address, status; malformed gets ? and address.
// - With the flag set outputs hold the safe value; output sets are ignored.
module relay_cmd #(
  parameter int unsigned TICK_CYCLES = `RM_TICK_MS * `RM_NS_PER_MS / `RM_CLK_NS
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [7:0]           paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  input  wire logic                 cfg_strap_n_i,
  input  wire relay_cmd_pkg::nv_s   nv_i,
  output relay_cmd_pkg::nv_s        nv_o,
  output logic                      nv_we_o,
  output logic      [6:0]           out_o,
  output logic                      led_o,
  output logic                      proto_mb_o
);
  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

  //----------------------------------------------------------------
  // State
  //----------------------------------------------------------------
  logic [7:0]             addr_r;
  relay_cmd_pkg::mbarg_s  mbarg_r;
  relay_cmd_pkg::resp_s   resp_r;
  relay_cmd_pkg::resp_s   resp_nxt;
  logic                   rvld_r;
  relay_cmd_pkg::nv_s     nv_r;
  logic [6:0]             out_r;
  logic [TW-1:0]          tick_r;
  logic [7:0]             tenth_r;
  logic                   led_r;
  logic                   proto_r;
  logic [1:0]             boot_r;
  logic                   strap_s1_r;
  logic                   strap_s2_r;
  logic                   nv_we_r;
  logic [31:0]            rdata_r;

  //----------------------------------------------------------------
  // APB decode
  //----------------------------------------------------------------
  // Zero wait states; ce_i low stretches writes, but a read with ce_i low in its setup cycle returns stale data.
  wire hit_ctrl = paddr_i == `RM_OFF_CTRL;
  wire hit_cmd  = paddr_i == `RM_OFF_CMD;
  wire hit_mb   = paddr_i == `RM_OFF_MBARG;
  wire hit_resp = paddr_i == `RM_OFF_RESP;
  wire hit_stat = paddr_i == `RM_OFF_STAT;
  wire hit_any  = hit_ctrl | hit_cmd | hit_mb | hit_resp | hit_stat;
  wire acc      = psel_i & penable_i & ce_i;
  wire wr_en    = acc & pwrite_i & hit_any;
  wire rd_setup = psel_i & ~penable_i & ~pwrite_i & ce_i;
  assign pready_o  = ce_i;
  assign pslverr_o = acc & ~hit_any;

  //----------------------------------------------------------------
  // Command decode
  //----------------------------------------------------------------
  relay_cmd_pkg::cmd_s cmd;
  assign cmd = relay_cmd_pkg::cmd_s'(pwdata_i);
  wire boot_ld = boot_r == `RM_BOOT_LD;
  wire cmd_go  = wr_en & hit_cmd;
  wire mine    = cmd_go & ~cmd.bcast & (cmd.tgt == addr_r);
  wire host_ok = cmd_go & cmd.bcast & (cmd.op == relay_cmd_pkg::op_host_ok);
  wire known   = cmd.op <= relay_cmd_pkg::op_mb_rd;
  // The device refuses a protocol change unless the strap is grounded.
  wire bad     = ~known | (cmd.op == relay_cmd_pkg::op_host_ok)
               | ((cmd.op == relay_cmd_pkg::op_wdt_set) & (cmd.val == 8'h00))
               | ((cmd.op == relay_cmd_pkg::op_prot_set) & strap_s2_r);
  wire ok      = mine & ~bad;
  wire is_stat = ok & (cmd.op == relay_cmd_pkg::op_stat_rd);
  wire stat_clr = ok & (cmd.op == relay_cmd_pkg::op_stat_rst);
  wire wset    = ok & (cmd.op == relay_cmd_pkg::op_wdt_set);
  wire vset    = ok & (cmd.op == relay_cmd_pkg::op_val_set);
  wire pset    = ok & (cmd.op == relay_cmd_pkg::op_prot_set);
  wire oset    = ok & (cmd.op == relay_cmd_pkg::op_out_set);
  wire is_mb   = ok & (cmd.op == relay_cmd_pkg::op_mb_rd);

  //----------------------------------------------------------------
  // Modbus coil read
  //----------------------------------------------------------------
  // Start address bits 15..3 pick the region, bits 2..0 the first coil.
  wire [12:0] mb_reg  = mbarg_r.start[15:3];
  wire [2:0]  mb_off  = mbarg_r.start[2:0];
  wire [2:0]  mb_qty  = mbarg_r.qty[2:0];
  wire        reg_out = mb_reg == `RM_MB_REG_OUT;
  wire        reg_sf  = mb_reg == `RM_MB_REG_SAFE;
  wire        reg_pon = mb_reg == `RM_MB_REG_PON;
  wire        addr_ok = (reg_out | reg_sf | reg_pon) & (mb_off != 3'h7);
  wire        qty_ok  = (mbarg_r.qty[15:3] == 13'h0000) & (mb_qty != 3'h0)
                      & ({1'b0, mb_off} + {1'b0, mb_qty} <= 4'h7);
  wire        mb_ok   = addr_ok & qty_ok;
  wire [6:0]  mb_src  = reg_out ? out_r : (reg_sf ? nv_r.safe_val : nv_r.pon_val);
  wire [7:0]  mb_mask = 8'((8'h01 << mb_qty) - 8'h01);
  wire [7:0]  mb_byte = ({1'b0, mb_src} >> mb_off) & mb_mask;
  wire [7:0]  mb_exc  = addr_ok ? `RM_MB_EX_QTY : `RM_MB_EX_ADDR;

  //----------------------------------------------------------------
  // Watchdog timing
  //----------------------------------------------------------------
  // Tick divider and tenth counter both restart on host-alive, so expiry lands exactly wdt_cnt ticks later.
  wire tick    = tick_r == TW'(TICK_CYCLES - 1);
  wire timeout = tick & nv_r.wdt_en & ~nv_r.wdt_flag
               & (8'(tenth_r + 8'h01) == nv_r.wdt_cnt);

  //----------------------------------------------------------------
  // Reply assembly
  //----------------------------------------------------------------
  always_comb begin
    resp_nxt      = '0;
    resp_nxt.lead = `RM_CH_ACK;
    resp_nxt.addr = addr_r;
    unique case (cmd.op)
      relay_cmd_pkg::op_stat_rd:  resp_nxt.data = {8'h00, nv_r.wdt_flag ? `RM_ST_TMO : `RM_ST_CLEAR};
      relay_cmd_pkg::op_wdt_rd:   resp_nxt.data = {7'h00, nv_r.wdt_en, nv_r.wdt_cnt};
      relay_cmd_pkg::op_val_rd:   resp_nxt.data = {1'b0, cmd.arg ? nv_r.safe_val : nv_r.pon_val, 8'h00};
      relay_cmd_pkg::op_prot_rd:  resp_nxt.data = {8'h00, nv_r.proto_mb ? `RM_PR_MB : `RM_PR_ASCII};
      relay_cmd_pkg::op_out_set:  resp_nxt.lead = nv_r.wdt_flag ? `RM_CH_ACK : `RM_CH_OK;
      relay_cmd_pkg::op_mb_rd: begin
        resp_nxt.lead = `RM_CH_NONE;
        resp_nxt.data = mb_ok ? {`RM_MB_FC, mb_byte} : {`RM_MB_FC_EXC, mb_exc};
      end
      default:                    resp_nxt.data = 16'h0000;
    endcase
    if (bad) begin
      resp_nxt.lead = `RM_CH_NAK;
      resp_nxt.data = 16'h0000;
    end
  end

  //----------------------------------------------------------------
  // Bus-side registers
  //----------------------------------------------------------------
  // Read selection is declared ahead of the capture flop that samples it in the setup cycle.
  wire [31:0] stat_w = {11'h000, led_r, rvld_r, nv_r.proto_mb, proto_r, nv_r.wdt_cnt,
                        nv_r.wdt_en, nv_r.wdt_flag, out_r};
  wire [31:0] rd_mux = hit_ctrl ? {24'h00_0000, addr_r} :
                       hit_mb   ? 32'(mbarg_r) :
                       hit_resp ? 32'(resp_r) :
                       hit_stat ? stat_w : 32'h0000_0000;

  // A command to another address or a broadcast leaves no reply behind.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_r  <= `RM_RST_ADDR;
      mbarg_r <= '0;
      resp_r  <= '0;
      rvld_r  <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else if (ce_i) begin
      if (wr_en & hit_ctrl) addr_r <= pwdata_i[7:0];
      if (wr_en & hit_mb) mbarg_r <= relay_cmd_pkg::mbarg_s'(pwdata_i);
      if (cmd_go) rvld_r <= mine;
      if (mine) resp_r <= resp_nxt;
      if (rd_setup) rdata_r <= rd_mux;
    end
  end

  assign prdata_o = rdata_r;

  //----------------------------------------------------------------
  // Power-on load and strap sampling
  //----------------------------------------------------------------
  // The strap goes through two flops; the load waits until they are full.
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      strap_s1_r <= cfg_strap_n_i;
      strap_s2_r <= strap_s1_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) boot_r <= 2'h0;
    else if (ce_i && boot_r != 2'h3) boot_r <= 2'(boot_r + 2'h1);
  end

  //----------------------------------------------------------------
  // Nonvolatile image and outputs
  //----------------------------------------------------------------
  // Flag set by expiry wins over a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nv_r    <= '0;
      out_r   <= 7'h00;
      proto_r <= 1'b1;
      nv_we_r <= 1'b0;
    end else if (ce_i) begin
      nv_we_r <= timeout | stat_clr | wset | vset | pset;
      if (boot_ld) begin
        nv_r    <= nv_i;
        out_r   <= nv_i.wdt_flag ? nv_i.safe_val : nv_i.pon_val;
        proto_r <= strap_s2_r & nv_i.proto_mb;
      end else begin
        if (pset) nv_r.proto_mb <= cmd.arg;
        if (wset) begin
          nv_r.wdt_en  <= cmd.arg;
          nv_r.wdt_cnt <= cmd.val;
        end
        if (vset & cmd.arg) nv_r.safe_val <= out_r;
        if (vset & ~cmd.arg) nv_r.pon_val <= out_r;
        if (oset & ~nv_r.wdt_flag) out_r <= cmd.val[6:0];
        if (timeout) begin
          nv_r.wdt_flag <= 1'b1;
          nv_r.wdt_en   <= 1'b0;
          out_r         <= nv_r.safe_val;
        end else if (stat_clr) begin
          nv_r.wdt_flag <= 1'b0;
        end
      end
    end
  end

  // Tick divider, tenth counter and LED flasher.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_r  <= '0;
      tenth_r <= 8'h00;
      led_r   <= 1'b0;
    end else if (ce_i) begin
      tick_r  <= (tick | host_ok | wset) ? '0 : TW'(tick_r + 1'b1);
      if (host_ok | wset | ~nv_r.wdt_en) tenth_r <= 8'h00;
      else if (tick) tenth_r <= 8'(tenth_r + 8'h01);
      if (~nv_r.wdt_flag | stat_clr) led_r <= 1'b0;
      else if (tick) led_r <= ~led_r;
    end
  end

  assign nv_o       = nv_r;
  assign nv_we_o    = nv_we_r;
  assign out_o      = out_r;
  assign led_o      = led_r;
  assign proto_mb_o = proto_r;

  //----------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_stat_code;
    is_stat && !boot_ld |=> resp_r.data == {8'h00, $past(nv_r.wdt_flag) ? 8'h04 : 8'h00};
  endproperty
  a_stat_code: assert property (p_stat_code) else $error("status code wrong");
  property p_prot_code;
    ok && cmd.op == relay_cmd_pkg::op_prot_rd && !boot_ld |=>
      resp_r.data[7:0] == ($past(nv_r.proto_mb) ? 8'h11 : 8'h10);
  endproperty
  a_prot_code: assert property (p_prot_code) else $error("protocol code wrong");
  property p_host_ok;
    host_ok |=> !rvld_r && tenth_r == 8'h00;
  endproperty
  a_host_ok: assert property (p_host_ok) else $error("host-alive mishandled");
  property p_sticky;
    ce_i && nv_r.wdt_flag && !stat_clr && !boot_ld |=> nv_r.wdt_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_clear;
    stat_clr && !timeout && !boot_ld |=> !nv_r.wdt_flag && !led_r && resp_r.lead == 8'h21;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");
  property p_expire;
    ce_i && timeout && !boot_ld |=> nv_r.wdt_flag && !nv_r.wdt_en && out_r == $past(nv_r.safe_val);
  endproperty
  a_expire: assert property (p_expire) else $error("timeout effects missing");
  property p_ignore;
    oset && nv_r.wdt_flag && !boot_ld |=> out_r == $past(out_r) && resp_r.lead == 8'h21;
  endproperty
  a_ignore: assert property (p_ignore) else $error("output set not ignored");
  property p_mb_exc;
    is_mb && !mb_ok |=> resp_r.data[15:8] == 8'h81 && resp_r.data[7:0] != 8'h00;
  endproperty
  a_mb_exc: assert property (p_mb_exc) else $error("exception reply wrong");

  c_timeout: cover property (ce_i && timeout);
  c_clear:   cover property (stat_clr && nv_r.wdt_flag);
  c_mb_ok:   cover property (is_mb && mb_ok);
  c_host_ok: cover property (host_ok);
endmodule

/* relay_cmd_pkg.sv */
package relay_cmd_pkg;
  typedef enum logic [3:0] {
    op_stat_rd  = 4'h0,
    op_stat_rst = 4'h1,
    op_wdt_rd   = 4'h2,
    op_wdt_set  = 4'h3,
    op_val_rd   = 4'h4,
    op_val_set  = 4'h5,
    op_prot_rd  = 4'h6,
    op_prot_set = 4'h7,
    op_host_ok  = 4'h8,
    op_out_set  = 4'h9,
    op_mb_rd    = 4'hA
  } op_e;
  // Command word as written by software.
  typedef struct packed {
    logic [6:0] rsvd_hi;
    logic       bcast;
    logic [7:0] tgt;
    logic [7:0] val;
    logic [2:0] rsvd_lo;
    logic       arg;
    op_e        op;
  } cmd_s;
  typedef struct packed {
    logic [15:0] start;
    logic [15:0] qty;
  } mbarg_s;
  typedef struct packed {
    logic [7:0]  lead;
    logic [7:0]  addr;
    logic [15:0] data;
  } resp_s;
  // Image of the nonvolatile store.
  typedef struct packed {
    logic       proto_mb;
    logic       wdt_flag;
    logic       wdt_en;
    logic [7:0] wdt_cnt;
    logic [6:0] safe_val;
    logic [6:0] pon_val;
  } nv_s;
endpackage

/* relay_cmd_regs.svh */
`ifndef RELAY_CMD_REGS_SVH
`define RELAY_CMD_REGS_SVH
// APB register offsets and reset module address.
`define RM_OFF_CTRL    8'h00
`define RM_OFF_CMD     8'h04
`define RM_OFF_MBARG   8'h08
`define RM_OFF_RESP    8'h0C
`define RM_OFF_STAT    8'h10
`define RM_RST_ADDR    8'h01
// Reply lead characters.
`define RM_CH_ACK      8'h21
`define RM_CH_NAK      8'h3F
`define RM_CH_OK       8'h3E
`define RM_CH_NONE     8'h00
// Reply payload codes.
`define RM_ST_CLEAR    8'h00
`define RM_ST_TMO      8'h04
`define RM_PR_ASCII    8'h10
`define RM_PR_MB       8'h11
`define RM_MB_FC       8'h01
`define RM_MB_FC_EXC   8'h81
`define RM_MB_EX_ADDR  8'h02
`define RM_MB_EX_QTY   8'h03
// Coil regions, start address bits 15..3.
`define RM_MB_REG_OUT  13'h0000
`define RM_MB_REG_SAFE 13'h0010
`define RM_MB_REG_PON  13'h0014
// Timing.
`define RM_TICK_MS     100
`define RM_NS_PER_MS   1000000
`define RM_CLK_NS      10
`define RM_BOOT_LD     2'h2
`endif

/* relay_cmd_test.sv */
`timescale 1ns/1ps

module relay_cmd_test;
  logic               clk_i   = 1'b0;
  logic               rst_i   = 1'b1;
  logic               psel    = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite  = 1'b0;
  logic [7:0]         paddr   = 8'h00;
  logic [31:0]        pwdata  = 32'h0000_0000;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               strap_n = 1'b1;
  relay_cmd_pkg::nv_s nv_rd;
  relay_cmd_pkg::nv_s nv_wr;
  logic               nv_we;
  logic [6:0]         out;
  logic               led;
  logic               proto_mb;
  logic [31:0]        q;
  logic               se;
  int                 err_total  = 0;
  int                 n_compared = 0;
  int                 v;
  int                 m_out, m_safe, m_pon, m_flag, m_proto;

  // ----------------------------------------
  // Clock, design and store
  // ----------------------------------------
  always #5 clk_i = ~clk_i;

  relay_cmd #(.TICK_CYCLES(20)) relay_cmd_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .cfg_strap_n_i(strap_n), .nv_i(nv_rd), .nv_o(nv_wr), .nv_we_o(nv_we),
    .out_o(out), .led_o(led), .proto_mb_o(proto_mb)
  );

  // A fresh store holds only the Modbus protocol choice; every other field is clear.
  nv_store #(.INIT_IMG(25'h100_0000)) nv_store_i (
    .clk_i(clk_i), .we_i(nv_we), .wr_img_i(nv_wr), .rd_img_o(nv_rd)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; a stuck slave is caught by the bench watchdog, not by this task.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) begin
      @(posedge clk_i);
    end
    q = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Issue a command to module 01 and read back the reply word into q.
  task automatic cmd(input logic [3:0] op, input logic arg, input logic [7:0] val, input logic bc);
    apb(1'b1, 8'h04, {7'h00, bc, 8'h01, val, 3'h0, arg, op});
    apb(1'b0, 8'h0C, 32'h0000_0000);
  endtask

  // Reset with the strap settled first, then wait past the boot load.
  task automatic power_cycle(input logic s);
    @(posedge clk_i);
    strap_n <= s;
    rst_i   <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    m_out = m_flag ? m_safe : m_pon;
  endtask

  task automatic led_count;
    v = 0;
    repeat (45) begin
      @(posedge clk_i);
      v += led;
    end
  endtask

  task automatic tend(input string name);
    $display("Test %s finished, mismatches so far %0d", name, err_total);
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  // The watchdog span is about thirty times the expected run, so slow but correct timing never trips it.
  initial begin
    #200_000;
    err_total++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'hd695b4cd));
    {m_out, m_safe, m_pon, m_flag} = '0;
    m_proto = 1;
    power_cycle(1'b1);
    chk({31'h0, proto_mb}, m_proto);
    chk({25'h0, out}, m_out);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({31'h0, se}, 1);
    cmd(4'h0, 1'b0, 8'h00, 1'b0);
    chk(q, 32'h2101_0000);
    cmd(4'hB, 1'b0, 8'h00, 1'b0);
    chk(q, 32'h3F01_0000);
    tend("status");
    // Random output patterns become the safe and power-on values.
    for (int k = 0; k < 2; k++) begin
      v = $urandom_range(127, 1);
      cmd(4'h9, 1'b0, 8'(v), 1'b0);
      chk(q, 32'h3E01_0000);
      m_out = v;
      chk({25'h0, out}, m_out);
      cmd(4'h5, k == 0, 8'h00, 1'b0);
      chk(q, 32'h2101_0000);
      if (k == 0) m_safe = m_out;
      else m_pon = m_out;
    end
    cmd(4'h4, 1'b1, 8'h00, 1'b0);
    chk(q, 32'h2101_0000 | (m_safe << 8));
    cmd(4'h4, 1'b0, 8'h00, 1'b0);
    chk(q, 32'h2101_0000 | (m_pon << 8));
    tend("stored");
    for (int r = 0; r < 3; r++) begin
      apb(1'b1, 8'h08, {(r == 0) ? 16'h0000 : (r == 1) ? 16'h0080 : 16'h00A0, 16'h0007});
      cmd(4'hA, 1'b0, 8'h00, 1'b0);
      chk(q & 32'hFF00_FFFF, 32'h0100 | ((r == 0) ? m_out : (r == 1) ? m_safe : m_pon));
    end
    apb(1'b1, 8'h08, 32'h0000_0003);
    cmd(4'hA, 1'b0, 8'h00, 1'b0);
    chk(q & 32'hFF00_FFFF, 32'h0100 | (m_out & 7));
    apb(1'b1, 8'h08, 32'h0007_0001);
    cmd(4'hA, 1'b0, 8'h00, 1'b0);
    chk(q & 32'hFF00_FFFF, 32'h0000_8102);
    apb(1'b1, 8'h08, 32'h0000_0000);
    cmd(4'hA, 1'b0, 8'h00, 1'b0);
    chk(q & 32'hFF00_FFFF, 32'h0000_8103);
    tend("modbus");
    cmd(4'h3, 1'b1, 8'h00, 1'b0);
    chk(q, 32'h3F01_0000);
    cmd(4'h3, 1'b1, 8'h03, 1'b0);
    chk(q, 32'h2101_0000);
    cmd(4'h2, 1'b0, 8'h00, 1'b0);
    chk(q, 32'h2101_0103);
    // Host-alive every 34 cycles keeps a 60-cycle period from expiring.
    repeat (6) begin
      cmd(4'h8, 1'b0, 8'h00, 1'b1);
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk({30'h0, q[19], q[7]}, 0);
      repeat (25) @(posedge clk_i);
    end
    repeat (80) @(posedge clk_i);
    m_flag = 1;
    m_out = m_safe;
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(q & 32'h0000_01FF, 32'h80 | m_out);
    cmd(4'h0, 1'b0, 8'h00, 1'b0);
    chk(q, 32'h2101_0004);
    cmd(4'h2, 1'b0, 8'h00, 1'b0);
    chk(q, 32'h2101_0003);
    cmd(4'h9, 1'b0, 8'h7F, 1'b0);
    chk(q, 32'h2101_0000);
    chk({25'h0, out}, m_out);
    led_count();
    chk({31'h0, v > 0 && v < 45}, 1);
    tend("watchdog");
    power_cycle(1'b1);
    chk({25'h0, out}, m_safe);
    cmd(4'h0, 1'b0, 8'h00, 1'b0);
    chk(q, 32'h2101_0004);
    cmd(4'h1, 1'b0, 8'h00, 1'b0);
    chk(q, 32'h2101_0000);
    m_flag = 0;
    cmd(4'h0, 1'b0, 8'h00, 1'b0);
    chk(q, 32'h2101_0000);
    led_count();
    chk(v, 0);
    tend("clear");
    cmd(4'h6, 1'b0, 8'h00, 1'b0);
    chk(q, 32'h2101_0011);
    cmd(4'h7, 1'b0, 8'h00, 1'b0);
    chk(q, 32'h3F01_0000);
    strap_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    cmd(4'h7, 1'b0, 8'h00, 1'b0);
    chk(q, 32'h2101_0000);
    m_proto = 0;
    cmd(4'h6, 1'b0, 8'h00, 1'b0);
    chk(q, 32'h2101_0010);
    chk({31'h0, proto_mb}, 1);
    power_cycle(1'b1);
    chk({31'h0, proto_mb}, m_proto);
    strap_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    cmd(4'h7, 1'b1, 8'h00, 1'b0);
    m_proto = 1;
    power_cycle(1'b0);
    chk({31'h0, proto_mb}, 0);
    power_cycle(1'b1);
    chk({31'h0, proto_mb}, m_proto);
    tend("protocol");
    print_verdict();
  end
endmodule
